// ===== design/timer_ctrl.sv
/*
 timer_ctrl: control bits, prescaler, pwm counters and pulse-train
 sequencing of a two-counter timer unit, behind an avalon-mm slave.
 assumes pin_a and pin_b come from pads outside the clock domain and a
 pad cell that resolves pin_a from pin_a_out and pin_a_oe.
*/
// Our own choices: the Avalon-MM register port and the address map.
// What this block does
// - when pin a is a pwm output its level bit holds the level driven.
// - hardware flips the level bit as the pwm toggles; software may access it.
// - a software write to the level bit beats a same-cycle hardware toggle.
// - the level bit drives nothing while pin a is an input or unit is off.
// - the unit runs only while enabled; otherwise counter logic stands.
// - while disabled, writes to counters, reloads and pending bits are void.
// - disabling clears the prescaler and pending bits and releases pin a.
// - pulse-train enable with mode 00 puts counter one in pulse-train mode.
// - pulse-train enable does nothing when mode select is not 00.
// - with software trigger enabled, a written event trigger starts a train.
// - with software trigger off, an edge on pin b starts a train.
// - trigger enable and event trigger matter only in pulse-train mode.
// - the event trigger clears when counter two underflows at train end.
// - with software trigger off, trigger writes are void; a 1 marks a pin start.
`timescale 1ns/1ns
module timer_ctrl #(
	parameter int unsigned CNT_W = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [timer_pkg::AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic pin_a_in,
	output logic pin_a_out,
	output logic pin_a_oe,
	input wire logic pin_b_in,
	output logic irq
);
	// ==========================================================
	// elaboration check
	generate
		if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
			$error("CNT_W must lie in 2..32");
		end
	endgenerate

	// ==========================================================
	// state
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_mux;
	timer_pkg::ctrl_s ctrl_q;
	logic [CNT_W-1:0] cnt1_q;
	logic [CNT_W-1:0] cnt2_q;
	logic [CNT_W-1:0] cra_q;
	logic [CNT_W-1:0] crb_q;
	logic [timer_pkg::PEND_W-1:0] pend_q;
	logic [timer_pkg::PEND_W-1:0] mask_q;
	logic [timer_pkg::PEND_W-1:0] pend_set;
	logic [timer_pkg::PEND_W-1:0] pend_clr;
	logic [7:0] presc_q;
	timer_pkg::train_e train_q;
	logic pa_s1_q;
	logic pa_s2_q;
	logic pb_s1_q;
	logic pb_s2_q;
	logic pb_s3_q;

	// ==========================================================
	// decode
	function automatic logic hit(input logic [timer_pkg::AW-1:0] a,
		input logic [timer_pkg::AW-1:0] off);
		return a == off;
	endfunction

	logic req;
	logic wr_fire;
	logic rd_fire;
	logic wr_ctrl;
	logic wr_on;
	logic pt_mode;
	logic running;
	logic tick;
	logic toggle;
	logic pulse_done;
	logic end_ev;
	logic pin_edge;
	logic start_sw;
	logic start_pin;
	logic idle;

	assign req = avs_read | avs_write;
	// a frozen clock enable must not let the master see an answer
	assign avs_waitrequest = req & ~(ack_q & ce);
	assign wr_fire = avs_write & ack_q & ce;
	assign rd_fire = avs_read & ack_q & ce;
	assign wr_ctrl = wr_fire & hit(avs_address, timer_pkg::OFF_CTRL);
	assign wr_on = wr_fire & ctrl_q.en;
	assign pt_mode = ctrl_q.pten & (ctrl_q.mode == timer_pkg::MODE_PWM);
	assign idle = train_q == timer_pkg::TRAIN_IDLE;
	assign running = ctrl_q.en & (ctrl_q.mode == timer_pkg::MODE_PWM)
		& (~ctrl_q.pten | ~idle);
	assign tick = ctrl_q.en & ce & (presc_q == ctrl_q.presc);
	assign toggle = running & tick & (cnt1_q == '0);
	assign pulse_done = toggle & ctrl_q.level;
	assign end_ev = pulse_done & pt_mode & (cnt2_q == '0);
	assign pin_edge = pb_s2_q ^ pb_s3_q;
	assign start_sw = pt_mode & ctrl_q.se & ctrl_q.et;
	assign start_pin = pt_mode & ~ctrl_q.se & pin_edge & ctrl_q.en;
	assign pend_set = {pin_edge & ctrl_q.en, end_ev, toggle};
	// only the bits the master actually saw are cleared by the read
	assign pend_clr = (rd_fire & hit(avs_address, timer_pkg::OFF_PEND))
		? rdata_q[timer_pkg::PEND_W-1:0] : '0;

	// ==========================================================
	// pin synchronisers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pa_s1_q <= 1'b0;
			pa_s2_q <= 1'b0;
			pb_s1_q <= 1'b0;
			pb_s2_q <= 1'b0;
			pb_s3_q <= 1'b0;
		end else if (ce) begin
			pa_s1_q <= pin_a_in;
			pa_s2_q <= pa_s1_q;
			pb_s1_q <= pin_b_in;
			pb_s2_q <= pb_s1_q;
			pb_s3_q <= pb_s2_q;
		end
	end

	// ==========================================================
	// bus slave: one wait cycle, read data captured in that cycle
	always_comb begin
		rd_mux = '0;
		case (avs_address)
			timer_pkg::OFF_CTRL: begin
				rd_mux[timer_pkg::MODE_LSB +: 2] = ctrl_q.mode;
				rd_mux[timer_pkg::PIN_A_EN_BIT] = ctrl_q.pin_a_en;
				rd_mux[timer_pkg::LEVEL_BIT] = ctrl_q.level;
				rd_mux[timer_pkg::EN_BIT] = ctrl_q.en;
				rd_mux[timer_pkg::PTEN_BIT] = ctrl_q.pten;
				rd_mux[timer_pkg::PTSE_BIT] = ctrl_q.se;
				rd_mux[timer_pkg::PTET_BIT] = ctrl_q.et;
				rd_mux[timer_pkg::PRESC_LSB +: 8] = ctrl_q.presc;
			end
			timer_pkg::OFF_CNT1: rd_mux[CNT_W-1:0] = cnt1_q;
			timer_pkg::OFF_CNT2: rd_mux[CNT_W-1:0] = cnt2_q;
			timer_pkg::OFF_CRA: rd_mux[CNT_W-1:0] = cra_q;
			timer_pkg::OFF_CRB: rd_mux[CNT_W-1:0] = crb_q;
			timer_pkg::OFF_PEND: rd_mux[timer_pkg::PEND_W-1:0] = pend_q;
			timer_pkg::OFF_MASK: rd_mux[timer_pkg::PEND_W-1:0] = mask_q;
			timer_pkg::OFF_PINS: rd_mux[1:0] = {pb_s2_q, pa_s2_q};
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else if (ce) begin
			ack_q <= req & ~ack_q;
			if (avs_read & ~ack_q) begin
				rdata_q <= rd_mux;
			end
		end
	end
	assign avs_readdata = rdata_q;

	// ==========================================================
	// control register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= timer_pkg::CTRL_RST;
		end else if (ce) begin
			if (wr_ctrl) begin
				ctrl_q.mode <= avs_writedata[timer_pkg::MODE_LSB +: 2];
				ctrl_q.pin_a_en <= avs_writedata[timer_pkg::PIN_A_EN_BIT];
				ctrl_q.en <= avs_writedata[timer_pkg::EN_BIT];
				ctrl_q.pten <= avs_writedata[timer_pkg::PTEN_BIT];
				ctrl_q.se <= avs_writedata[timer_pkg::PTSE_BIT];
				ctrl_q.presc <= avs_writedata[timer_pkg::PRESC_LSB +: 8];
				ctrl_q.level <= avs_writedata[timer_pkg::LEVEL_BIT];
			end else if (toggle) begin
				ctrl_q.level <= ~ctrl_q.level;
			end
			if (wr_ctrl && ctrl_q.se) begin
				ctrl_q.et <= avs_writedata[timer_pkg::PTET_BIT];
			end else if (end_ev) begin
				ctrl_q.et <= 1'b0;
			end else if (start_pin && idle) begin
				ctrl_q.et <= 1'b1;
			end
		end
	end

	// ==========================================================
	// prescaler: cleared while off so a restart begins a full period
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			presc_q <= timer_pkg::PRESC_RST;
		end else if (ce) begin
			if (!ctrl_q.en || tick) begin
				presc_q <= timer_pkg::PRESC_RST;
			end else begin
				presc_q <= presc_q + 8'h01;
			end
		end
	end

	// ==========================================================
	// pulse-train sequencer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			train_q <= timer_pkg::TRAIN_IDLE;
		end else if (ce) begin
			if (!pt_mode || !ctrl_q.en) begin
				train_q <= timer_pkg::TRAIN_IDLE;
			end else begin
				unique case (train_q)
					timer_pkg::TRAIN_IDLE: begin
						if (start_sw || start_pin) begin
							train_q <= timer_pkg::TRAIN_RUN;
						end
					end
					timer_pkg::TRAIN_RUN: begin
						if (end_ev) begin
							train_q <= timer_pkg::TRAIN_IDLE;
						end
					end
				endcase
			end
		end
	end

	// ==========================================================
	// counters and reloads; counter one alternates high and low times
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt1_q <= '0;
		end else if (ce) begin
			if (wr_on && hit(avs_address, timer_pkg::OFF_CNT1)) begin
				cnt1_q <= avs_writedata[CNT_W-1:0];
			end else if (toggle) begin
				cnt1_q <= ctrl_q.level ? crb_q : cra_q;
			end else if (running && tick) begin
				cnt1_q <= cnt1_q - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt2_q <= '0;
		end else if (ce) begin
			if (wr_on && hit(avs_address, timer_pkg::OFF_CNT2)) begin
				cnt2_q <= avs_writedata[CNT_W-1:0];
			end else if (pulse_done && pt_mode) begin
				cnt2_q <= cnt2_q - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cra_q <= '0;
			crb_q <= '0;
		end else if (ce) begin
			if (wr_on && hit(avs_address, timer_pkg::OFF_CRA)) begin
				cra_q <= avs_writedata[CNT_W-1:0];
			end
			if (wr_on && hit(avs_address, timer_pkg::OFF_CRB)) begin
				crb_q <= avs_writedata[CNT_W-1:0];
			end
		end
	end

	// ==========================================================
	// interrupts: set beats the read clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pend_q <= timer_pkg::PEND_RST;
			mask_q <= timer_pkg::PEND_RST;
		end else if (ce) begin
			if (!ctrl_q.en) begin
				pend_q <= timer_pkg::PEND_RST;
			end else if (wr_on && hit(avs_address, timer_pkg::OFF_PEND)) begin
				pend_q <= avs_writedata[timer_pkg::PEND_W-1:0] | pend_set;
			end else begin
				pend_q <= (pend_q & ~pend_clr) | pend_set;
			end
			if (wr_fire && hit(avs_address, timer_pkg::OFF_MASK)) begin
				mask_q <= avs_writedata[timer_pkg::PEND_W-1:0];
			end
		end
	end
	assign irq = |(pend_q & mask_q);

	// ==========================================================
	// pin a: released to an input whenever the unit is off
	assign pin_a_oe = ctrl_q.en & ctrl_q.pin_a_en;
	assign pin_a_out = ctrl_q.level;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_pin_start;
		ce && idle && start_pin;
	endsequence
	sequence s_train_on;
		train_q == timer_pkg::TRAIN_RUN && ctrl_q.et;
	endsequence

	a_pin_level_mirror: assert property (
		pin_a_oe |-> pin_a_out == ctrl_q.level)
		else $error("pin a differs from level bit");
	a_hw_level_flip: assert property (
		toggle && !wr_ctrl |=> ctrl_q.level != $past(ctrl_q.level))
		else $error("level bit did not toggle");
	a_sw_level_wins: assert property (
		wr_ctrl |=> ctrl_q.level == $past(avs_writedata[timer_pkg::LEVEL_BIT]))
		else $error("software level write lost");
	a_pin_released: assert property (
		!ctrl_q.en || !ctrl_q.pin_a_en |-> !pin_a_oe)
		else $error("pin a driven while input or off");
	a_off_counters_hold: assert property (
		!ctrl_q.en ##1 !ctrl_q.en |-> $stable(cnt1_q) && $stable(cnt2_q))
		else $error("counter moved while unit off");
	a_off_write_void: assert property (
		wr_fire && !ctrl_q.en && hit(avs_address, timer_pkg::OFF_CRA)
		|=> $stable(cra_q))
		else $error("reload written while unit off");
	a_off_clears: assert property (
		ce && !ctrl_q.en |=> pend_q == '0 && presc_q == '0 && !irq)
		else $error("disable did not clear state");
	a_no_train_other: assert property (
		ce && !pt_mode |=> idle)
		else $error("train runs outside pulse-train mode");
	a_sw_start: assert property (
		ce && idle && ctrl_q.en && start_sw |=> train_q == timer_pkg::TRAIN_RUN)
		else $error("software trigger did not start train");
	a_pin_start: assert property (
		s_pin_start |=> s_train_on)
		else $error("pin edge did not start train");
	a_end_clears: assert property (
		end_ev && !wr_ctrl |=> !ctrl_q.et && idle)
		else $error("train end left trigger set");
	a_et_write_void: assert property (
		wr_ctrl && !ctrl_q.se && !end_ev && !start_pin
		|=> $stable(ctrl_q.et))
		else $error("trigger written with software trigger off");
endmodule

// ===== design/timer_pkg.sv
/*
 timer_pkg: register map, control field layout, reset values and shared
 types of the timer control block.
 assumes a 32-bit avalon-mm slave port with byte addresses.
*/
package timer_pkg;
	// ==========================================================
	// register map
	localparam int unsigned AW = 5;
	localparam logic [AW-1:0] OFF_CTRL = 5'h00;
	localparam logic [AW-1:0] OFF_CNT1 = 5'h04;
	localparam logic [AW-1:0] OFF_CNT2 = 5'h08;
	localparam logic [AW-1:0] OFF_CRA = 5'h0C;
	localparam logic [AW-1:0] OFF_CRB = 5'h10;
	localparam logic [AW-1:0] OFF_PEND = 5'h14;
	localparam logic [AW-1:0] OFF_MASK = 5'h18;
	localparam logic [AW-1:0] OFF_PINS = 5'h1C;
	// ==========================================================
	// control word field positions
	localparam int unsigned MODE_LSB = 0;
	localparam int unsigned PIN_A_EN_BIT = 4;
	localparam int unsigned LEVEL_BIT = 6;
	localparam int unsigned EN_BIT = 7;
	localparam int unsigned PTEN_BIT = 8;
	localparam int unsigned PTSE_BIT = 9;
	localparam int unsigned PTET_BIT = 10;
	localparam int unsigned PRESC_LSB = 16;
	// ==========================================================
	// pending bits and the pwm mode code
	localparam int unsigned PEND_W = 3;
	localparam int unsigned PEND_CNT1 = 0;
	localparam int unsigned PEND_END = 1;
	localparam int unsigned PEND_PINB = 2;
	localparam logic [1:0] MODE_PWM = 2'h0;
	// ==========================================================
	// types
	typedef struct packed {
		logic [7:0] presc;
		logic et;
		logic se;
		logic pten;
		logic en;
		logic level;
		logic pin_a_en;
		logic [1:0] mode;
	} ctrl_s;
	localparam ctrl_s CTRL_RST = 16'h0000;
	localparam logic [PEND_W-1:0] PEND_RST = 3'h0;
	localparam logic [7:0] PRESC_RST = 8'h00;
	typedef enum logic {TRAIN_IDLE, TRAIN_RUN} train_e;
endpackage

// ===== sim/pads_model.sv
/*
 pads_model: external circuitry on the two timer pins.
 assumes pin a has a pull-down and pin b changes level once per kick.
*/
`timescale 1ns/1ns
module pads_model (
	input wire logic clk,
	input wire logic kick,
	input wire logic pin_a_out,
	input wire logic pin_a_oe,
	output logic pin_a_in,
	output logic pin_b_in
);
	// ==========================================================
	// pin a pad: the pull-down shows once the block lets go
	assign pin_a_in = pin_a_oe ? pin_a_out : 1'b0;
	// ==========================================================
	// pin b source: one level change per kick
	initial pin_b_in = 1'b0;
	always @(posedge clk) begin
		if (kick) begin
			pin_b_in <= ~pin_b_in;
		end
	end
endmodule

// ===== sim/timer_control_pulse_train_tb.sv
/*
 timer_control_pulse_train_tb: scenario tasks for the timer control block.
 assumes timer_ctrl, timer_pkg and pads_model; ce is held high.
*/
`timescale 1ns/1ns
module timer_control_pulse_train_tb;
	localparam logic [31:0] EN = 32'h1 << timer_pkg::EN_BIT;
	localparam logic [31:0] PA = 32'h1 << timer_pkg::PIN_A_EN_BIT;
	localparam logic [31:0] LV = 32'h1 << timer_pkg::LEVEL_BIT;
	localparam logic [31:0] PT = 32'h1 << timer_pkg::PTEN_BIT;
	localparam logic [31:0] SE = 32'h1 << timer_pkg::PTSE_BIT;
	localparam logic [31:0] ET = 32'h1 << timer_pkg::PTET_BIT;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic kick = 1'b0;
	logic [timer_pkg::AW-1:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, pin_a_in, pin_a_out, pin_a_oe, pin_b_in, irq;
	int mismatches = 0;
	int total_checks = 0;
	always #10 clk = ~clk;
	timer_ctrl #(.CNT_W(16)) DUT (.clk(clk), .resetn(resetn), .ce(1'b1),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pin_a_in(pin_a_in), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
		.pin_b_in(pin_b_in), .irq(irq));
	pads_model pads (.clk(clk), .kick(kick), .pin_a_out(pin_a_out),
		.pin_a_oe(pin_a_oe), .pin_a_in(pin_a_in), .pin_b_in(pin_b_in));
	// ==========================================================
	// shared tasks
	task automatic finish_test();
		if (mismatches == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// called just after a rising edge; a wait that never ends is the
	// watchdog's job, not ours
	task automatic bus(input logic wr, input logic [timer_pkg::AW-1:0] a,
		input logic [31:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [timer_pkg::AW-1:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [timer_pkg::AW-1:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask
	task automatic wait_et_clear();
		logic [31:0] q;
		int n;
		q = ET;
		for (n = 0; n < 60 && q[timer_pkg::PTET_BIT] !== 1'b0; n++) begin
			rd(timer_pkg::OFF_CTRL, q);
		end
		chk("trigger end", 32'h0, {31'h0, q[timer_pkg::PTET_BIT]});
		rd(timer_pkg::OFF_PEND, q);
		chk("end pending", 32'h1, {31'h0, q[timer_pkg::PEND_END]});
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset_locked();
		logic [31:0] q;
		logic [timer_pkg::AW-1:0] regs[5] = '{timer_pkg::OFF_CNT1,
			timer_pkg::OFF_CNT2, timer_pkg::OFF_CRA, timer_pkg::OFF_CRB,
			timer_pkg::OFF_PEND};
		rd(timer_pkg::OFF_CTRL, q);
		chk("ctrl reset", 32'h0, q);
		chk("oe reset", 32'h0, {31'h0, pin_a_oe});
		foreach (regs[i]) begin
			wr(regs[i], 32'h5);
			rd(regs[i], q);
			chk("locked write", 32'h0, q);
		end
		rd(5'h1E, q);
		chk("unmapped", 32'h0, q);
	endtask
	task automatic t_pwm_irq();
		logic [31:0] q;
		logic [31:0] q2;
		int flips;
		wr(timer_pkg::OFF_CTRL, EN | 32'h1);
		wr(timer_pkg::OFF_CRA, 32'h3);
		wr(timer_pkg::OFF_CRB, 32'h3);
		wr(timer_pkg::OFF_MASK, 32'h0);
		wr(timer_pkg::OFF_CTRL, EN | PA);
		// reloads of 3 give a level change every 4 clocks
		flips = 0;
		q[0] = pin_a_out;
		for (int i = 0; i < 60; i++) begin
			@(posedge clk);
			if (pin_a_out !== q[0]) flips++;
			q[0] = pin_a_out;
		end
		chk("pwm toggles", 32'h1, {31'h0, flips >= 14 && flips <= 16});
		chk("oe on", 32'h1, {31'h0, pin_a_oe});
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(timer_pkg::OFF_MASK, 32'h1);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(timer_pkg::OFF_CTRL, EN | PA | 32'h1);
		rd(timer_pkg::OFF_CTRL, q);
		chk("level bit", {31'h0, pin_a_out}, {31'h0, q[6]});
		rd(timer_pkg::OFF_PINS, q);
		chk("pin a pad", {31'h0, pin_a_out}, {31'h0, q[0]});
		rd(timer_pkg::OFF_PEND, q);
		rd(timer_pkg::OFF_PEND, q);
		chk("pend cleared", 32'h0, q);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(timer_pkg::OFF_CTRL, EN | PA | LV | 32'h1);
		chk("sw level", 32'h1, {31'h0, pin_a_out});
		wr(timer_pkg::OFF_CTRL, EN | LV | 32'h1);
		chk("level no drive", 32'h0, {31'h0, pin_a_oe});
		wr(timer_pkg::OFF_CTRL, EN | PA);
		repeat (30) @(posedge clk);
		wr(timer_pkg::OFF_CTRL, PA | LV);
		chk("oe off", 32'h0, {31'h0, pin_a_oe});
		rd(timer_pkg::OFF_PEND, q);
		chk("pend reset", 32'h0, q);
		rd(timer_pkg::OFF_CNT1, q);
		repeat (10) @(posedge clk);
		rd(timer_pkg::OFF_CNT1, q2);
		chk("stopped count", q, q2);
	endtask
	task automatic t_soft();
		logic [31:0] q;
		wr(timer_pkg::OFF_CTRL, EN);
		wr(timer_pkg::OFF_CNT2, 32'h1);
		wr(timer_pkg::OFF_CTRL, EN | PA | PT | SE);
		q[0] = pin_a_out;
		repeat (30) @(posedge clk);
		chk("no start", {31'h0, q[0]}, {31'h0, pin_a_out});
		wr(timer_pkg::OFF_CTRL, EN | PA | PT | SE | ET);
		rd(timer_pkg::OFF_CTRL, q);
		chk("soft start", 32'h1, {31'h0, q[timer_pkg::PTET_BIT]});
		wait_et_clear();
	endtask
	task automatic t_pin();
		logic [31:0] q;
		wr(timer_pkg::OFF_CNT2, 32'h1);
		wr(timer_pkg::OFF_CTRL, EN | PA | PT);
		wr(timer_pkg::OFF_CTRL, EN | PA | PT | ET);
		rd(timer_pkg::OFF_CTRL, q);
		chk("trigger void", 32'h0, {31'h0, q[timer_pkg::PTET_BIT]});
		kick <= 1'b1;
		@(posedge clk);
		kick <= 1'b0;
		repeat (6) @(posedge clk);
		rd(timer_pkg::OFF_CTRL, q);
		chk("pin start", 32'h1, {31'h0, q[timer_pkg::PTET_BIT]});
		wait_et_clear();
	endtask
	task automatic t_other_mode();
		logic [31:0] q;
		logic [31:0] q2;
		wr(timer_pkg::OFF_CTRL, EN | PA | PT | SE | ET | 32'h1);
		rd(timer_pkg::OFF_CNT1, q);
		repeat (20) @(posedge clk);
		rd(timer_pkg::OFF_CNT1, q2);
		chk("mode 01 hold", q, q2);
		chk("mode 01 out", 32'h0, {31'h0, pin_a_out});
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_reset_locked();
		t_pwm_irq();
		t_soft();
		t_pin();
		t_other_mode();
		finish_test();
	end
	initial begin
		#400000;
		mismatches++;
		finish_test();
	end
endmodule
